// [include/dcf_defines.vh]
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH
`define DCF_DEPTH 9'h100
`define DCF_AW 8
`define DCF_CW 9
`define DCF_DW 36
`define DCF_REG_LOW 8'h00
`define DCF_REG_HIGH 8'h04
`define DCF_REG_STAT 8'h08
`define DCF_REG_CTRL 8'h0C
`define DCF_CTRL_FLUSH 0
`define DCF_STAT_OUTV 9
`define DCF_STAT_SPACE 10
`define DCF_STAT_AE 11
`define DCF_STAT_AF 12
`define DCF_STAT_FWFT 13
`define DCF_STAT_BIG 14
`define DCF_STAT_SER 15
`define DCF_OFF_8 8'h08
`define DCF_OFF_16 8'h10
`define DCF_OFF_64 8'h40
`define DCF_OFF_RST 8'h08
`define DCF_SER_BITS 5'h10
`endif

// [src/dcf_fifo.v]
// Contract
// - Almost-empty low when words at or below X
// - Almost-full low when free at or below Y
// - Almost-empty changes on port B edges only
// - Almost-full changes on port A edges only
// - Port A is 36-bit two-way data bus
// - Port B is 36-bit two-way, width selectable
// - Select high at reset: big-endian order
// - Select low at reset: little-endian order
// - After reset select picks standard or fall-through
// - Width select low long word, else narrow
// - Port A clock free-running, clocks transfers
// - Full and almost-full change on A edges
// - Port A transfer needs select low
// - Port A outputs released while select high
// - Port B transfer needs select low
// - Port B outputs released while select high
// - Standard mode: flag shows memory empty
// - Fall-through mode: flag shows valid output word
// - Empty/ready flag changes on B edges only
// - Transfers also need port enable high
// - Full flag: full or space available
// - Flags pass two stages in own domain
`timescale 1ns/100ps
`include "dcf_defines.vh"
`default_nettype none
module dcf_fifo (
  input wire clk,
  input wire nrst,
  input wire port_a_clock,
  input wire port_a_select_n,
  input wire port_a_strobe_gate,
  input wire port_a_write_sel,
  input wire [35:0] port_a_bus_in,
  output reg [35:0] port_a_bus_out,
  output reg port_a_bus_oe,
  input wire port_b_clock,
  input wire port_b_select_n,
  input wire port_b_strobe_gate,
  input wire port_b_read_sel,
  input wire [35:0] port_b_bus_in,
  output reg [35:0] port_b_bus_out,
  output reg port_b_bus_oe,
  input wire endian_or_timing_select,
  input wire port_b_width_select,
  input wire port_b_size_sel,
  input wire offset_preset_sel0,
  input wire offset_preset_sel1,
  input wire serial_prog_sel,
  output reg full_or_in_space,
  output reg almost_full_n,
  output reg empty_or_out_valid,
  output reg almost_empty_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  // Flops only; a 256 deep array costs area but keeps one clock
  reg [`DCF_DW-1:0] mem_q [0:`DCF_DEPTH-1];
  reg [`DCF_AW-1:0] wptr_q;
  reg [`DCF_AW-1:0] rptr_q;
  reg [`DCF_CW-1:0] cnt_q;
  reg [`DCF_DW-1:0] hold_q;
  reg hv_q;
  reg [1:0] part_q;
  reg a_clk_q;
  reg b_clk_q;
  reg big_q;
  reg fwft_q;
  reg mode_set_q;
  reg ser_q;
  reg par_q;
  reg [4:0] ser_cnt_q;
  reg [7:0] low_q;
  reg [7:0] high_q;
  reg flush_q;
  reg ff_s1_q;
  reg af_s1_q;
  reg ef_s1_q;
  reg ae_s1_q;

  wire a_edge = port_a_clock & ~a_clk_q;
  wire b_edge = port_b_clock & ~b_clk_q;
  wire has_room = cnt_q != `DCF_DEPTH;
  wire has_data = cnt_q != {`DCF_CW{1'b0}};
  wire [`DCF_CW-1:0] free_cnt = `DCF_DEPTH - cnt_q;
  wire [`DCF_DW-1:0] head = mem_q[rptr_q];

  wire [1:0] last_part = port_b_width_select ?
    (port_b_size_sel ? 2'h3 : 2'h1) : 2'h0;
  wire at_last = part_q == last_part;

  wire wr_en = a_edge & ~port_a_select_n & port_a_strobe_gate &
    port_a_write_sel & has_room;
  wire rd_req = b_edge & ~port_b_select_n & port_b_strobe_gate &
    port_b_read_sel;
  wire pop = has_data & (fwft_q ?
    (b_edge & (~hv_q | (rd_req & at_last))) :
    (rd_req & (part_q == 2'h0)));

  wire [1:0] part_nx = at_last ? 2'h0 : part_q + 2'h1;
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_wr = wb_req & wb_we_i & wb_ack_o;
  wire ff_raw = has_room;
  wire ef_raw = fwft_q ? hv_q : (has_data | (part_q != 2'h0));
  wire ae_raw = cnt_q > {1'b0, low_q};
  wire af_raw = free_cnt > {1'b0, high_q};

  function [35:0] dcf_slice;
    input [35:0] w;
    input [1:0] k;
    input [1:0] lp;
    input big;
    reg [1:0] p;
    begin
      p = big ? lp - k : k;
      case (lp)
        2'h0: dcf_slice = w;
        2'h1: dcf_slice = {{18{1'b0}}, p[0] ? w[35:18] : w[17:0]};
        default:
        begin
          case (p)
            2'h0: dcf_slice = {{27{1'b0}}, w[8:0]};
            2'h1: dcf_slice = {{27{1'b0}}, w[17:9]};
            2'h2: dcf_slice = {{27{1'b0}}, w[26:18]};
            default: dcf_slice = {{27{1'b0}}, w[35:27]};
          endcase
        end
      endcase
    end
  endfunction

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      a_clk_q <= 1'b1;
      b_clk_q <= 1'b1;
    end
    else
    begin
      a_clk_q <= port_a_clock;
      b_clk_q <= port_b_clock;
    end
  end

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wptr_q] <= port_a_bus_in;
    end
  end

  // Straps are caught in the synchronous reset branch, except the width selects, used live, and the timing select, taken in the first cycle after reset
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      big_q <= endian_or_timing_select;
      fwft_q <= 1'b0;
      mode_set_q <= 1'b0;
      ser_q <= serial_prog_sel;
      par_q <= ~serial_prog_sel & ~offset_preset_sel1 &
        ~offset_preset_sel0;
      ser_cnt_q <= 5'h00;
      if (serial_prog_sel)
      begin
        low_q <= `DCF_OFF_RST;
        high_q <= `DCF_OFF_RST;
      end
      else if (offset_preset_sel1 & offset_preset_sel0)
      begin
        low_q <= `DCF_OFF_64;
        high_q <= `DCF_OFF_64;
      end
      else if (offset_preset_sel1)
      begin
        low_q <= `DCF_OFF_16;
        high_q <= `DCF_OFF_16;
      end
      else
      begin
        low_q <= `DCF_OFF_8;
        high_q <= `DCF_OFF_8;
      end
    end
    else
    begin
      if (!mode_set_q)
      begin
        fwft_q <= ~endian_or_timing_select;
        mode_set_q <= 1'b1;
      end
      if (ser_q & a_edge & ~offset_preset_sel1 &
          (ser_cnt_q != `DCF_SER_BITS))
      begin
        {high_q, low_q} <= {high_q[6:0], low_q, offset_preset_sel0};
        ser_cnt_q <= ser_cnt_q + 5'h01;
      end
      else if (par_q & wb_wr & wb_sel_i[0])
      begin
        if (wb_adr_i == `DCF_REG_LOW)
        begin
          low_q <= wb_dat_i[7:0];
        end
        else if (wb_adr_i == `DCF_REG_HIGH)
        begin
          high_q <= wb_dat_i[7:0];
        end
      end
    end
  end

  always @(posedge clk)
  begin
    if (!nrst || flush_q)
    begin
      wptr_q <= {`DCF_AW{1'b0}};
      rptr_q <= {`DCF_AW{1'b0}};
      cnt_q <= {`DCF_CW{1'b0}};
      hv_q <= 1'b0;
      part_q <= 2'h0;
      hold_q <= {`DCF_DW{1'b0}};
      port_b_bus_out <= {`DCF_DW{1'b0}};
    end
    else
    begin
      if (wr_en)
      begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop)
      begin
        rptr_q <= rptr_q + 1'b1;
      end
      if (wr_en & ~pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop & ~wr_en)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (pop)
      begin
        hold_q <= head;
        hv_q <= 1'b1;
        port_b_bus_out <= dcf_slice(head, 2'h0, last_part, big_q);
        part_q <= fwft_q ? 2'h0 : part_nx;
      end
      else if (rd_req & fwft_q & hv_q)
      begin
        hv_q <= ~at_last;
        part_q <= part_nx;
        port_b_bus_out <= dcf_slice(hold_q, part_nx, last_part, big_q);
      end
      else if (rd_req & ~fwft_q & (part_q != 2'h0))
      begin
        part_q <= part_nx;
        port_b_bus_out <= dcf_slice(hold_q, part_q, last_part, big_q);
      end
    end
  end

  // Flags lag the count; reads and writes are still guarded by it
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      ff_s1_q <= 1'b0;
      af_s1_q <= 1'b0;
      ef_s1_q <= 1'b0;
      ae_s1_q <= 1'b0;
      full_or_in_space <= 1'b0;
      almost_full_n <= 1'b0;
      empty_or_out_valid <= 1'b0;
      almost_empty_n <= 1'b0;
    end
    else
    begin
      if (a_edge)
      begin
        ff_s1_q <= ff_raw;
        af_s1_q <= af_raw;
        full_or_in_space <= ff_s1_q;
        almost_full_n <= af_s1_q;
      end
      if (b_edge)
      begin
        ef_s1_q <= ef_raw;
        ae_s1_q <= ae_raw;
        empty_or_out_valid <= ef_s1_q;
        almost_empty_n <= ae_s1_q;
      end
    end
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      port_a_bus_oe <= 1'b0;
      port_b_bus_oe <= 1'b0;
      port_a_bus_out <= {`DCF_DW{1'b0}};
    end
    else
    begin
      port_a_bus_oe <= ~port_a_select_n & ~port_a_write_sel;
      port_b_bus_oe <= ~port_b_select_n & port_b_read_sel;
      port_a_bus_out <= {{20{1'b0}}, high_q, low_q};
    end
  end

  // Wishbone slave, ack one cycle after the strobe
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      flush_q <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      flush_q <= wb_wr & wb_sel_i[0] & (wb_adr_i == `DCF_REG_CTRL) &
        wb_dat_i[`DCF_CTRL_FLUSH];
      if (wb_req & ~wb_ack_o)
      begin
        wb_dat_o <= 32'h0000_0000;
        if (wb_adr_i == `DCF_REG_LOW)
        begin
          wb_dat_o[7:0] <= low_q;
        end
        else if (wb_adr_i == `DCF_REG_HIGH)
        begin
          wb_dat_o[7:0] <= high_q;
        end
        else if (wb_adr_i == `DCF_REG_STAT)
        begin
          wb_dat_o[`DCF_CW-1:0] <= cnt_q;
          wb_dat_o[`DCF_STAT_OUTV] <= empty_or_out_valid;
          wb_dat_o[`DCF_STAT_SPACE] <= full_or_in_space;
          wb_dat_o[`DCF_STAT_AE] <= almost_empty_n;
          wb_dat_o[`DCF_STAT_AF] <= almost_full_n;
          wb_dat_o[`DCF_STAT_FWFT] <= fwft_q;
          wb_dat_o[`DCF_STAT_BIG] <= big_q;
          wb_dat_o[`DCF_STAT_SER] <= ser_cnt_q == `DCF_SER_BITS;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [verification/dcf_fifo_props.sv]
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_bus_oe,
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_bus_oe,
  input wire logic full_or_in_space,
  input wire logic almost_full_n,
  input wire logic empty_or_out_valid,
  input wire logic almost_empty_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  logic a_hist_q;
  logic b_hist_q;
  wire a_edge = port_a_clock && !a_hist_q;
  wire b_edge = port_b_clock && !b_hist_q;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Port clocks are levels, so edges are rebuilt here
  always @(posedge clk)
  begin
    a_hist_q <= port_a_clock;
    b_hist_q <= port_b_clock;
  end
  property p_af;
    $changed(almost_full_n) |-> $past(a_edge);
  endproperty
  a_af: assert property (p_af) else $error("af off A edge");
  property p_ff;
    $changed(full_or_in_space) |-> $past(a_edge);
  endproperty
  a_ff: assert property (p_ff) else $error("ff off A edge");
  property p_ae;
    $changed(almost_empty_n) |-> $past(b_edge);
  endproperty
  a_ae: assert property (p_ae) else $error("ae off B edge");
  property p_ef;
    $changed(empty_or_out_valid) |-> $past(b_edge);
  endproperty
  a_ef: assert property (p_ef) else $error("ef off B edge");
  property p_oea;
    port_a_select_n |=> !port_a_bus_oe;
  endproperty
  a_oea: assert property (p_oea) else $error("A bus driven");
  property p_oeb;
    port_b_select_n |=> !port_b_bus_oe;
  endproperty
  a_oeb: assert property (p_oeb) else $error("B bus driven");
  property p_full;
    !full_or_in_space |-> !almost_full_n;
  endproperty
  a_full: assert property (p_full) else $error("af high when full");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
endmodule
bind dcf_fifo dcf_fifo_props u_props (.clk(clk), .nrst(nrst),
  .port_a_clock(port_a_clock), .port_a_select_n(port_a_select_n),
  .port_a_bus_oe(port_a_bus_oe), .port_b_clock(port_b_clock),
  .port_b_select_n(port_b_select_n), .port_b_bus_oe(port_b_bus_oe),
  .full_or_in_space(full_or_in_space), .almost_full_n(almost_full_n),
  .empty_or_out_valid(empty_or_out_valid),
  .almost_empty_n(almost_empty_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// [verification/dcf_port_partner.sv]
`timescale 1ns/100ps
`default_nettype none
module dcf_port_partner (
  input wire logic clk,
  output logic port_a_clock = 1'b0,
  output logic port_b_clock = 1'b0
);
  logic [1:0] a_cnt_q = 2'h0;
  logic [1:0] b_cnt_q = 2'h0;
  // free-running clocks
  // Unequal periods keep the two ports out of step
  always @(posedge clk)
  begin
    a_cnt_q <= a_cnt_q + 2'h1;
    b_cnt_q <= (b_cnt_q == 2'h2) ? 2'h0 : b_cnt_q + 2'h1;
    if (a_cnt_q[0])
      port_a_clock <= ~port_a_clock;
    if (b_cnt_q == 2'h2)
      port_b_clock <= ~port_b_clock;
  end
endmodule
`default_nettype wire

// [verification/dcf_fifo_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defines.vh"
module dcf_fifo_bench;
  logic clk, a_clk, b_clk, a_oe, b_oe, ff, af, ef, ae, ack;
  logic nrst = 1'b0, a_sn = 1'b0, a_g = 1'b0, a_w = 1'b1, b_sn = 1'b0;
  logic b_g = 1'b0, endi = 1'b0, wsel = 1'b0, bsz = 1'b0, fs0 = 1'b0;
  logic fs1 = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, spm = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [35:0] a_in = 36'h0, a_out, b_out, v;
  integer bad_count = 0, comparisons = 0, ticks = 0, i;
  dcf_fifo dut (.clk(clk), .nrst(nrst), .port_a_clock(a_clk),
    .port_a_select_n(a_sn), .port_a_strobe_gate(a_g),
    .port_a_write_sel(a_w), .port_a_bus_in(a_in), .port_a_bus_out(a_out),
    .port_a_bus_oe(a_oe), .port_b_clock(b_clk), .port_b_select_n(b_sn),
    .port_b_strobe_gate(b_g), .port_b_read_sel(1'b1),
    .port_b_bus_in(36'h0), .port_b_bus_out(b_out), .port_b_bus_oe(b_oe),
    .endian_or_timing_select(endi), .port_b_width_select(wsel),
    .port_b_size_sel(bsz), .offset_preset_sel0(fs0),
    .offset_preset_sel1(fs1), .serial_prog_sel(spm),
    .full_or_in_space(ff), .almost_full_n(af), .empty_or_out_valid(ef),
    .almost_empty_n(ae), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  dcf_port_partner peer (.clk(clk), .port_a_clock(a_clk),
    .port_b_clock(b_clk));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task conclude();
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      bad_count = bad_count + 1;
      conclude();
    end
  end
  task check(input string nm, input logic [35:0] s, input logic [35:0] e);
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  function logic [35:0] wd(input logic [7:0] n);
    wd = {10'h100, n, 10'h200, n};
  endfunction
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // One gated port edge; the gate is dropped right after it
  task pulse(input logic b);
    @(posedge clk);
    while ((b ? b_clk : a_clk) !== 1'b0)
      @(posedge clk);
    a_g <= !b;
    b_g <= b;
    @(posedge clk);
    while ((b ? b_clk : a_clk) !== 1'b1)
      @(posedge clk);
    a_g <= 1'b0;
    b_g <= 1'b0;
  endtask
  task put(input logic [35:0] d);
    a_in <= d;
    pulse(1'b0);
  endtask
  task rst(input logic big, std, nar, byt, input logic [1:0] s);
    nrst <= 1'b0;
    endi <= big;
    wsel <= nar;
    bsz <= byt;
    {fs1, fs0} <= s;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    endi <= std;
    repeat (2) @(posedge clk);
  endtask
  task s_regs(input logic [7:0] o, input logic big, input logic fw);
    wb(1'b1, `DCF_REG_LOW, 32'h0000_0033);
    wb(1'b0, `DCF_REG_LOW, 32'h0);
    check("x", {4'h0, q}, {28'h0, o});
    wb(1'b0, `DCF_REG_HIGH, 32'h0);
    check("y", {4'h0, q}, {28'h0, o});
    wb(1'b0, `DCF_REG_STAT, 32'h0);
    check("mode", {34'h0, q[14:13]}, {34'h0, big, fw});
    wb(1'b0, 8'h10, 32'h0);
    check("hole", {4'h0, q}, 36'h0);
  endtask
  task s_flags(input logic [3:0] e);
    repeat (40) @(posedge clk);
    check("ef_ae", {34'h0, ef, ae}, {34'h0, e[3:2]});
    check("ff_af", {34'h0, ff, af}, {34'h0, e[1:0]});
  endtask
  task s_fill(input integer n, input logic [8:0] c);
    for (i = 0; i < n; i++)
      put(wd(i[7:0]));
    a_sn <= 1'b1;
    put(36'h0);
    a_sn <= 1'b0;
    wb(1'b0, `DCF_REG_STAT, 32'h0);
    check("count", {27'h0, q[8:0]}, {27'h0, c});
  endtask
  task s_bytes;
    v = wd(8'h00);
    for (i = 0; i < 4; i++)
    begin
      pulse(1'b1);
      repeat (2) @(posedge clk);
      check("byte", b_out, {27'h0, v[35-9*i -: 9]});
    end
  endtask
  task s_oe;
    b_sn <= 1'b1;
    a_w <= 1'b0;
    pulse(1'b0);
    repeat (2) @(posedge clk);
    check("oe", {34'h0, a_oe, b_oe}, 36'h2);
    check("a_bus", a_out, 36'h0_0000_0808);
    b_sn <= 1'b0;
    a_sn <= 1'b1;
    repeat (2) @(posedge clk);
    check("oe", {34'h0, a_oe, b_oe}, 36'h1);
    a_sn <= 1'b0;
    a_w <= 1'b1;
  endtask
  task s_fwft;
    for (i = 0; i < 3; i++)
      put(wd(i[7:0]));
    s_flags(4'b1011);
    for (i = 0; i < 3; i++)
    begin
      v = wd(i[7:0]);
      repeat (8) @(posedge clk);
      check("lo", b_out, {18'h0, v[17:0]});
      pulse(1'b1);
      repeat (2) @(posedge clk);
      check("hi", b_out, {18'h0, v[35:18]});
      pulse(1'b1);
    end
  endtask
  // Parallel offsets, threshold edge, long word read and flush
  task s_prog;
    wb(1'b1, `DCF_REG_LOW, 32'h0000_0005);
    wb(1'b1, `DCF_REG_HIGH, 32'h0000_0006);
    wb(1'b0, `DCF_REG_LOW, 32'h0);
    check("px", {4'h0, q}, 36'h0_0000_0005);
    wb(1'b0, `DCF_REG_HIGH, 32'h0);
    check("py", {4'h0, q}, 36'h0_0000_0006);
    for (i = 0; i < 5; i++)
      put(wd(i[7:0] + 8'h40));
    s_flags(4'b1011);
    put(wd(8'h45));
    s_flags(4'b1111);
    pulse(1'b1);
    repeat (2) @(posedge clk);
    check("long", b_out, wd(8'h40));
    wb(1'b1, `DCF_REG_CTRL, 32'h0000_0001);
    wb(1'b0, `DCF_REG_STAT, 32'h0);
    check("flush", {27'h0, q[8:0]}, 36'h0);
  endtask
  // Serial offsets: Y msb goes in first, X lsb last
  task s_serial(input logic [15:0] d);
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      while (a_clk !== 1'b0)
        @(posedge clk);
      fs0 <= d[15 - i];
      fs1 <= 1'b0;
      @(posedge clk);
      while (a_clk !== 1'b1)
        @(posedge clk);
      fs1 <= 1'b1;
    end
    wb(1'b0, `DCF_REG_LOW, 32'h0);
    check("sx", {4'h0, q}, {28'h0, d[7:0]});
    wb(1'b0, `DCF_REG_HIGH, 32'h0);
    check("sy", {4'h0, q}, {28'h0, d[15:8]});
    wb(1'b0, `DCF_REG_STAT, 32'h0);
    check("sdone", {35'h0, q[15]}, 36'h1);
  endtask
  initial
  begin
    rst(1'b1, 1'b1, 1'b1, 1'b1, 2'b01);
    s_regs(8'h08, 1'b1, 1'b0);
    s_flags(4'b0011);
    s_fill(10, 9'h00a);
    s_flags(4'b1111);
    s_bytes;
    s_oe;
    s_fill(248, 9'h100);
    s_flags(4'b1100);
    rst(1'b0, 1'b0, 1'b1, 1'b0, 2'b10);
    s_regs(8'h10, 1'b0, 1'b1);
    s_fwft;
    s_flags(4'b0011);
    rst(1'b1, 1'b1, 1'b0, 1'b0, 2'b00);
    s_prog;
    spm <= 1'b1;
    rst(1'b1, 1'b1, 1'b0, 1'b0, 2'b10);
    s_serial(16'h2a15);
    conclude();
  end
endmodule
`default_nettype wire
